// ==== rtl/scd_cmd_decode.sv ====
// Combinational classifier that turns a command code into a decoded command.
`timescale 1ns/1ps
module scd_cmd_decode (
  // Raw code.
  input wire logic [7:0] code,
  // Decoded command.
  output scd_pkg::scd_cmd_t cmd,
  output logic immediate
);

  // Pattern match over the code; fixed codes are checked before field patterns.
  always_comb begin
    logic [5:0] low;
    low = code[5:0];
    cmd.op = scd_pkg::OP_INVALID;
    cmd.count_select = {code[scd_pkg::COUNT_SELECT_HIGH_BIT], code[scd_pkg::COUNT_SELECT_LOW_BIT]};
    cmd.attention_request_bit = 1'b0;
    cmd.message_phase_bit = 1'b0;
    cmd.command_or_data_bit = 1'b0;
    if (code == scd_pkg::CODE_CHIP_RESET) begin
      cmd.op = scd_pkg::OP_CHIP_RESET;
    end else if (code == scd_pkg::CODE_BREAK) begin
      cmd.op = scd_pkg::OP_BREAK;
    end else if (code == scd_pkg::CODE_BUS_RELEASE) begin
      cmd.op = scd_pkg::OP_BUS_RELEASE;
    end else if (code == scd_pkg::CODE_SET_ATTENTION) begin
      cmd.op = scd_pkg::OP_SET_ATTENTION;
    end else if (code == scd_pkg::CODE_RELEASE_ACK) begin
      cmd.op = scd_pkg::OP_RELEASE_ACK;
    end else if (code == scd_pkg::CODE_FLUSH_FIFO) begin
      cmd.op = scd_pkg::OP_FLUSH_FIFO;
    end else if (code == scd_pkg::CODE_SCSI_RESET) begin
      cmd.op = scd_pkg::OP_SCSI_RESET;
    end else if (code == scd_pkg::CODE_RESELECT) begin
      cmd.op = scd_pkg::OP_RESELECT;
    end else if (code == scd_pkg::CODE_AUTO_TARGET) begin
      cmd.op = scd_pkg::OP_AUTO_TARGET;
    end else if (code == scd_pkg::CODE_AUTO_TARGET_TERM) begin
      cmd.op = scd_pkg::OP_AUTO_TARGET_TERM;
    end else if (code[7:4] == 4'h1 && code[2:0] == 3'h0) begin
      cmd.op = scd_pkg::OP_SELECT;
      cmd.attention_request_bit = code[scd_pkg::ATTENTION_BIT];
    end else if (low == scd_pkg::LOW_TRANSFER) begin
      cmd.op = scd_pkg::OP_TRANSFER;
    end else if (low[5:4] == 2'h1 && low[2:0] == 3'h4) begin
      cmd.op = scd_pkg::OP_AUTO_INIT;
      cmd.attention_request_bit = code[scd_pkg::ATTENTION_BIT];
    end else if (low == scd_pkg::LOW_AUTO_INIT2) begin
      cmd.op = scd_pkg::OP_AUTO_INIT2;
    end else if (low[5:3] == 3'h5) begin
      cmd.op = code[0] ? scd_pkg::OP_SEND : scd_pkg::OP_RECEIVE;
      cmd.message_phase_bit = code[scd_pkg::MESSAGE_BIT];
      cmd.command_or_data_bit = code[scd_pkg::COMMAND_DATA_BIT];
    end else if (low == scd_pkg::LOW_RESEL_RECEIVE) begin
      cmd.op = scd_pkg::OP_RESEL_RECEIVE;
    end else if (low == scd_pkg::LOW_RESEL_SEND) begin
      cmd.op = scd_pkg::OP_RESEL_SEND;
    end
    immediate = (cmd.op == scd_pkg::OP_CHIP_RESET) || (cmd.op == scd_pkg::OP_BREAK) ||
                (cmd.op == scd_pkg::OP_BUS_RELEASE) || (cmd.op == scd_pkg::OP_SET_ATTENTION) ||
                (cmd.op == scd_pkg::OP_RELEASE_ACK) || (cmd.op == scd_pkg::OP_FLUSH_FIFO) ||
                (cmd.op == scd_pkg::OP_SCSI_RESET);
  end

endmodule

// ==== rtl/scd_command_decoder.sv ====
// Command register decoder with extended status register for a SCSI-2 controller.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module scd_command_decoder (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Register port.
  input wire logic [scd_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rd_data,
  // Interrupt holding and status events from the rest of the controller.
  input wire logic firmware_interrupt_holding,
  input wire scd_pkg::scd_status_evt_t status_evt,
  // Decoded command towards the sequencers.
  output logic cmd_valid,
  output scd_pkg::scd_cmd_t cmd,
  output logic cmd_refused,
  output logic invalid_cmd,
  output logic int_sources_clear,
  output logic [7:0] extended_status
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  scd_pkg::scd_cmd_t dec_cmd;
  logic dec_immediate;
  logic cmd_write;
  logic is_sequence;
  logic is_release;
  logic is_chip_reset;
  logic is_invalid;

  scd_cmd_decode u_decode (
    .code(wr_data),
    .cmd(dec_cmd),
    .immediate(dec_immediate)
  );

  // Qualify a host write to the command location and sort the command by type.
  always_comb begin
    cmd_write = wr_stb && (addr == scd_pkg::CMD_CODE_ADDR);
    is_invalid = dec_cmd.op == scd_pkg::OP_INVALID;
    is_sequence = !dec_immediate && !is_invalid;
    is_release = dec_cmd.op == scd_pkg::OP_BUS_RELEASE;
    is_chip_reset = dec_cmd.op == scd_pkg::OP_CHIP_RESET;
  end

  // ----------------------------------------------------------------
  // Command issue
  // ----------------------------------------------------------------
  logic next_cmd_valid;
  scd_pkg::scd_cmd_t next_cmd;
  logic next_cmd_refused;
  logic next_invalid_cmd;
  logic next_int_sources_clear;

  // Work out the one-cycle pulses that follow a command write.
  always_comb begin
    next_cmd = cmd;
    next_cmd_valid = 1'b0;
    next_cmd_refused = 1'b0;
    next_invalid_cmd = 1'b0;
    next_int_sources_clear = 1'b0;
    if (cmd_write) begin
      if (is_invalid) begin
        next_invalid_cmd = 1'b1;
      end else if (is_sequence && firmware_interrupt_holding) begin
        next_cmd_refused = 1'b1;
      end else begin
        next_cmd_valid = 1'b1;
        next_cmd = dec_cmd;
      end
      next_int_sources_clear = is_sequence || is_release;
    end
  end

  // Register the command outputs.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_valid <= 1'b0;
      cmd <= '{op: scd_pkg::OP_INVALID, default: '0};
      cmd_refused <= 1'b0;
      invalid_cmd <= 1'b0;
      int_sources_clear <= 1'b0;
    end else begin
      cmd_valid <= next_cmd_valid;
      cmd <= next_cmd;
      cmd_refused <= next_cmd_refused;
      invalid_cmd <= next_invalid_cmd;
      int_sources_clear <= next_int_sources_clear;
    end
  end

  // ----------------------------------------------------------------
  // Extended status
  // ----------------------------------------------------------------
  logic [7:0] next_extended_status;
  logic [7:0] status_set;
  logic status_clear;

  // Sticky error bits; a new event in the clearing cycle survives the clear.
  always_comb begin
    status_set = 8'h00;
    status_set[scd_pkg::EXT_SCSI_PARITY_BIT] = status_evt.scsi_parity_error;
    status_set[scd_pkg::EXT_HOST_PARITY_BIT] = status_evt.host_parity_error;
    status_clear = cmd_write && (is_chip_reset || is_release || is_sequence);
    if (status_clear) begin
      next_extended_status = status_set;
    end else begin
      next_extended_status = extended_status | status_set;
    end
  end

  // Register the status; hardware reset returns it to zero.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      extended_status <= scd_pkg::EXT_STATUS_RESET;
    end else begin
      extended_status <= next_extended_status;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [7:0] next_rd_data;

  // Only the status reads back; the command location and holes read zero.
  always_comb begin
    next_rd_data = 8'h00;
    if (rd_stb && addr == scd_pkg::EXT_STATUS_ADDR) begin
      next_rd_data = extended_status;
    end
  end

  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= next_rd_data;
    end
  end

endmodule

// ==== rtl/scd_pkg.sv ====
// Package with register map, command codes and carrier types of the command decoder.
package scd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] CMD_CODE_ADDR = 4'h7;
  localparam logic [3:0] EXT_STATUS_ADDR = 4'h8;
  localparam logic [7:0] EXT_STATUS_RESET = 8'h00;
  localparam int EXT_SCSI_PARITY_BIT = 0;
  localparam int EXT_HOST_PARITY_BIT = 1;

  // ----------------------------------------------------------------
  // Fixed command codes and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_CHIP_RESET = 8'h00;
  localparam logic [7:0] CODE_BREAK = 8'h01;
  localparam logic [7:0] CODE_BUS_RELEASE = 8'h02;
  localparam logic [7:0] CODE_SET_ATTENTION = 8'h03;
  localparam logic [7:0] CODE_RELEASE_ACK = 8'h04;
  localparam logic [7:0] CODE_FLUSH_FIFO = 8'h05;
  localparam logic [7:0] CODE_SCSI_RESET = 8'h08;
  localparam logic [7:0] CODE_RESELECT = 8'h20;
  localparam logic [7:0] CODE_AUTO_TARGET = 8'h30;
  localparam logic [7:0] CODE_AUTO_TARGET_TERM = 8'h31;
  localparam logic [5:0] LOW_TRANSFER = 6'h12;
  localparam logic [5:0] LOW_AUTO_INIT2 = 6'h15;
  localparam logic [5:0] LOW_RESEL_RECEIVE = 6'h38;
  localparam logic [5:0] LOW_RESEL_SEND = 6'h39;
  localparam int COUNT_SELECT_HIGH_BIT = 7;
  localparam int COUNT_SELECT_LOW_BIT = 6;
  localparam int ATTENTION_BIT = 3;
  localparam int MESSAGE_BIT = 2;
  localparam int COMMAND_DATA_BIT = 1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_CHIP_RESET,
    OP_BREAK,
    OP_BUS_RELEASE,
    OP_SET_ATTENTION,
    OP_RELEASE_ACK,
    OP_FLUSH_FIFO,
    OP_SCSI_RESET,
    OP_SELECT,
    OP_TRANSFER,
    OP_AUTO_INIT,
    OP_AUTO_INIT2,
    OP_RESELECT,
    OP_RECEIVE,
    OP_SEND,
    OP_AUTO_TARGET,
    OP_AUTO_TARGET_TERM,
    OP_RESEL_RECEIVE,
    OP_RESEL_SEND,
    OP_INVALID
  } scd_op_t;

  typedef struct packed {
    scd_op_t op;
    logic [1:0] count_select;
    logic attention_request_bit;
    logic message_phase_bit;
    logic command_or_data_bit;
  } scd_cmd_t;

  typedef struct packed {
    logic scsi_parity_error;
    logic host_parity_error;
  } scd_status_evt_t;

endpackage

// ==== tb/scd_command_decoder_bench.sv ====
// Self-checking bench for the command decoder driven by the host model.
`timescale 1ns/1ps
module scd_command_decoder_bench;
  logic sys_clk, rst, wr_stb, rd_stb, hold, cmd_valid, cmd_refused, invalid_cmd, isc;
  logic [3:0] addr;
  logic [7:0] wr_data, rd_data, ext, got;
  scd_pkg::scd_status_evt_t evt;
  scd_pkg::scd_cmd_t cmd;
  int n_fail, checks_done;
  // Free-running clock.
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  scd_command_decoder scd_command_decoder_i (.sys_clk(sys_clk), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .firmware_interrupt_holding(hold), .status_evt(evt), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_refused(cmd_refused), .invalid_cmd(invalid_cmd), .int_sources_clear(isc),
    .extended_status(ext));
  scd_host_model scd_host_model_i (.sys_clk(sys_clk), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data));
  // Compares a seen value against an expected one.
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic results();
    if (n_fail == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Writes a command code and lets the answering pulses settle.
  task automatic cw(input logic [7:0] c);
    scd_host_model_i.wr(scd_pkg::CMD_CODE_ADDR, c);
    #1;
  endtask
  // Raises the given status events for one cycle.
  task automatic pulse_evt(input scd_pkg::scd_status_evt_t e);
    @(posedge sys_clk);
    evt <= e;
    hold <= 1'b0;
    @(posedge sys_clk);
    evt <= 2'b00;
    #1;
  endtask
  // Register and command state straight after reset.
  task automatic reset_values();
    scd_host_model_i.rd(scd_pkg::EXT_STATUS_ADDR, got);
    chk("status after reset", got, 8'h00);
    chk("op after reset", cmd.op, scd_pkg::OP_INVALID);
  endtask
  // One code for each decoded operation, listed in the order of the decoded operations.
  task automatic decode_all();
    logic [7:0] codes [18] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08, 8'h18,
      8'hd2, 8'h9c, 8'h55, 8'h20, 8'hae, 8'h2b, 8'h30, 8'h31, 8'h78, 8'hf9};
    logic [1:0] mc;
    for (int i = 0; i < 18; i++) begin
      cw(codes[i]);
      chk("issued", cmd_valid, 1'b1);
      chk("op", cmd.op, scd_pkg::scd_op_t'(i));
      chk("count select", cmd.count_select, codes[i][7:6]);
      chk("sources clear", isc, !(i inside {0, 1, 3, 4, 5, 6}));
      // Operand bits must be zero for every command that carries none.
      chk("attention", cmd.attention_request_bit, i == 7 || i == 9);
      mc = (i == 12 || i == 13) ? codes[i][2:1] : 2'h0;
      chk("msg cd", {cmd.message_phase_bit, cmd.command_or_data_bit}, mc);
    end
  endtask
  // Status set, read, write-protect, invalid code and the three clearing writes.
  task automatic status_paths();
    logic [7:0] c [3] = '{8'h02, 8'h00, 8'h30};
    scd_pkg::scd_status_evt_t e [3] = '{2'h2, 2'h1, 2'h3};
    logic [7:0] want;
    for (int i = 0; i < 3; i++) begin
      // Each event alone first, so that swapped bit positions show up.
      want = 8'h00;
      want[scd_pkg::EXT_SCSI_PARITY_BIT] = e[i].scsi_parity_error;
      want[scd_pkg::EXT_HOST_PARITY_BIT] = e[i].host_parity_error;
      pulse_evt(e[i]);
      chk("status set", ext, want);
      scd_host_model_i.wr(scd_pkg::EXT_STATUS_ADDR, 8'h00);
      scd_host_model_i.rd(scd_pkg::EXT_STATUS_ADDR, got);
      chk("status read", got, want);
      cw(8'h06);
      chk("invalid", {invalid_cmd, cmd_valid, isc}, 3'b100);
      chk("status kept", ext, want);
      @(posedge sys_clk) hold <= (i == 2);
      cw(c[i]);
      chk("status clear", ext, 8'h00);
      chk("refused", {cmd_refused, cmd_valid}, (i == 2) ? 2'b10 : 2'b01);
    end
    scd_host_model_i.rd(4'h3, got);
    chk("unmapped read", got, 8'h00);
  endtask
  // Reset in mid-run clears a set status and the held command.
  task automatic mid_reset();
    pulse_evt(2'h3);
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk("status after mid reset", ext, 8'h00);
    chk("op after mid reset", cmd.op, scd_pkg::OP_INVALID);
  endtask
  // Main sequence.
  initial begin
    rst = 1'b1;
    hold = 1'b0;
    evt = 2'b00;
    n_fail = 0;
    checks_done = 0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    reset_values();
    decode_all();
    status_paths();
    mid_reset();
    results();
  end
  // Cuts a hang short.
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    results();
  end
endmodule

// ==== tb/scd_host_model.sv ====
// Host model that issues single register accesses on the plain register port.
`timescale 1ns/1ps
module scd_host_model (
  // Clock.
  input wire logic sys_clk,
  // Register port towards the decoder.
  output logic [scd_pkg::ADDR_W-1:0] addr,
  output logic [7:0] wr_data,
  output logic wr_stb,
  output logic rd_stb,
  input wire logic [7:0] rd_data
);
  // Idle bus at time zero.
  initial begin
    addr = 4'h0;
    wr_data = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  // One write cycle carries a whole code; the bus is scrambled once it is released.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    addr <= ~a;
    wr_data <= ~d;
    wr_stb <= 1'b0;
  endtask
  // One read cycle; the data stand only in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    addr <= ~a;
    rd_stb <= 1'b0;
    #1;
    d = rd_data;
  endtask
endmodule

// ==== tb/scd_monitor.sv ====
// Checker with concurrent assertions on the command decoder ports.
`timescale 1ns/1ps
module scd_monitor (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Register port.
  input wire logic [scd_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rd_data,
  // Side inputs and decoded outputs.
  input wire logic firmware_interrupt_holding,
  input wire scd_pkg::scd_status_evt_t status_evt,
  input wire logic cmd_valid,
  input wire scd_pkg::scd_cmd_t cmd,
  input wire logic cmd_refused,
  input wire logic invalid_cmd,
  input wire logic int_sources_clear,
  input wire logic [7:0] extended_status
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // A command write of code c with no status event beside it.
  sequence wr_of(logic [7:0] c);
    wr_stb && addr == scd_pkg::CMD_CODE_ADDR && wr_data == c && status_evt == 2'b00;
  endsequence
  // Such a write while no firmware interrupt is held.
  sequence go_of(logic [7:0] c);
    wr_of(c) ##0 !firmware_interrupt_holding;
  endsequence
  idle_quiet_a: assert property (!(wr_stb && addr == scd_pkg::CMD_CODE_ADDR) |=>
    !cmd_valid && !invalid_cmd && !cmd_refused) else $error("command pulse without write");
  sel_decode_a: assert property (go_of(8'h18) |=> cmd_valid &&
    cmd.op == scd_pkg::OP_SELECT && cmd.attention_request_bit) else $error("select decode");
  term_decode_a: assert property (go_of(8'h31) |=>
    cmd.op == scd_pkg::OP_AUTO_TARGET_TERM) else $error("termination decode");
  rd_unmapped_a: assert property (rd_stb && addr != scd_pkg::EXT_STATUS_ADDR |=>
    rd_data == 8'h00) else $error("unmapped read not zero");
  status_ro_a: assert property (wr_stb && addr == scd_pkg::EXT_STATUS_ADDR &&
    status_evt == 2'b00 |=> $stable(extended_status)) else $error("status written");
  chip_clear_a: assert property (wr_of(8'h00) |=> cmd_valid &&
    extended_status == 8'h00 && !int_sources_clear) else $error("chip reset effects");
  release_clear_a: assert property (wr_of(8'h02) |=> cmd_valid && int_sources_clear
    && extended_status == 8'h00) else $error("bus release effects");
  refuse_seq_a: assert property (wr_of(8'h30) ##0 firmware_interrupt_holding |=>
    cmd_refused && !cmd_valid && int_sources_clear) else $error("held command ran");
  invalid_only_a: assert property (wr_of(8'h06) |=> invalid_cmd && !cmd_valid &&
    !int_sources_clear && $stable(extended_status)) else $error("invalid code effects");
endmodule

bind scd_command_decoder scd_monitor scd_monitor_i (.sys_clk(sys_clk), .rst(rst),
  .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
  .firmware_interrupt_holding(firmware_interrupt_holding), .status_evt(status_evt),
  .cmd_valid(cmd_valid), .cmd(cmd), .cmd_refused(cmd_refused), .invalid_cmd(invalid_cmd),
  .int_sources_clear(int_sources_clear), .extended_status(extended_status));
